// *** pcpp_pkg.sv ***
// Purpose: constants, field layout and mode codes of the counter programming port
// Assumes: one system clock samples every pin; pins reach the core through three flops
// Notes: the pin vector indices tie the top-level ports to the synchroniser
// Notes on behaviour
// (RQ1) serial words arrive most significant bit first
// (RQ2) serial clock rise shifts primary or enhancement register
// (RQ3) serial select one uses primary, zero secondary
// (RQ4) parallel select one uses primary, zero secondary
// (RQ5) prescaler enable high means prescaler bypassed
// (RQ6) enhancement strobe rise captures whole bus
// (RQ7) main upper strobe latches reference/main high bits
// (RQ8) main lower strobe latches prescaler bit, main low
// (RQ9) swallow strobe latches reference low, swallow bits
// (RQ10) hop strobe copies primary into secondary
// (RQ11) serial/parallel select picks interface when not direct
// (RQ12) direct select takes counters from hard-wired pins
// (RQ13) direct swallow value four pins, bit0 least
// (RQ14) parallel bus eight bits, bit7 most significant
// (RQ15) serial load rise copies primary into secondary
// (RQ16) enhancement bits act only with mode pin low
// (RQ17) shift registers fill from least significant end
package pcpp_pkg;
  localparam int PRIM_W = 20;
  localparam int ENH_W = 8;
  localparam int DATA_W = 8;
  localparam int REF_W = 6;
  localparam int MAIN_W = 9;
  localparam int SWAL_W = 4;
  localparam int SYNC_STAGES = 3;
  // primary word layout
  localparam int FLD_A_LSB = 0;
  localparam int FLD_RLO_LSB = 4;
  localparam int FLD_MLO_LSB = 8;
  localparam int FLD_PRE_BIT = 15;
  localparam int FLD_MHI_LSB = 16;
  localparam int FLD_RHI_LSB = 18;
  localparam int FLD_A_W = 4;
  localparam int FLD_RLO_W = 4;
  localparam int FLD_MLO_W = 7;
  localparam int FLD_MHI_W = 2;
  localparam int FLD_RHI_W = 2;
  // values after reset
  localparam logic [PRIM_W-1:0] PRIM_RST = 20'h00000;
  localparam logic [ENH_W-1:0] ENH_RST = 8'h00;
  // pin vector indices
  localparam int PIN_SDATA = 0;
  localparam int PIN_SCLK = 1;
  localparam int PIN_SLOAD = 2;
  localparam int PIN_EWEN = 3;
  localparam int PIN_SSEL = 4;
  localparam int PIN_PSEL = 5;
  localparam int PIN_ESTB = 6;
  localparam int PIN_MUSTB = 7;
  localparam int PIN_MLSTB = 8;
  localparam int PIN_SWSTB = 9;
  localparam int PIN_HOP = 10;
  localparam int PIN_SERSEL = 11;
  localparam int PIN_DIRSEL = 12;
  localparam int PIN_ENHMODE = 13;
  localparam int PIN_DATA = 14;
  localparam int PIN_DPRE = 22;
  localparam int PIN_DREF = 23;
  localparam int PIN_DMAIN = 29;
  localparam int PIN_DSWAL = 38;
  localparam int PIN_W = 42;
  typedef enum logic [1:0] {
    PCPP_MODE_PAR = 2'b00,
    PCPP_MODE_SER = 2'b01,
    PCPP_MODE_DIR = 2'b10
  } pcpp_mode_t;
endpackage

// *** pcpp_pin_if.sv ***
// Purpose: carries raw pins to the synchroniser and clean levels and rises back
// Assumes: one clock domain on both sides
// Notes: rise is combinational, high in the cycle before the clean level goes high
`timescale 1ns/1ns
interface pcpp_pin_if #(parameter int W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] level;
  logic [W-1:0] rise;
  modport sync (input raw, output level, output rise);
  modport core (output raw, input level, input rise);
endinterface

// *** pcpp_pin_sync.sv ***
// Purpose: three-flop synchroniser with agreement filter per pin
// Assumes: pins are asynchronous to clk_in
// Notes: a change counts once the second and third stages agree
`timescale 1ns/1ns
module pcpp_pin_sync #(
  parameter int W = 1
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic clk_en_in,
  pcpp_pin_if.sync pins
);
  import pcpp_pkg::*;
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic s1_reg, s2_reg, s3_reg, f_reg;
      logic s1_next, s2_next, s3_next, f_next;
      logic agree;
      // stage one feeds only stage two
      always_comb begin
        agree = (s2_reg == s3_reg);
        s1_next = pins.raw[i];
        s2_next = s1_reg;
        s3_next = s2_reg;
        f_next = agree ? s3_reg : f_reg;
      end
      // resets low to match the pull-downs on every input
      always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          s1_reg <= 1'b0;
          s2_reg <= 1'b0;
          s3_reg <= 1'b0;
          f_reg <= 1'b0;
        end else if (clk_en_in) begin
          s1_reg <= s1_next;
          s2_reg <= s2_next;
          s3_reg <= s3_next;
          f_reg <= f_next;
        end
      end
      assign pins.level[i] = f_reg;
      assign pins.rise[i] = agree & s3_reg & ~f_reg;
    end
  endgenerate
endmodule

// *** pcpp_port.sv ***
// Purpose: counter programming port: serial, parallel and direct loading
// Assumes: all pins asynchronous; data stable a few clocks before its strobe rises
// Notes: counter values leave on registered outputs; no reset pin on the part itself
`timescale 1ns/1ns
module pcpp_port (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic clk_en_in,
  input wire logic serial_data_in,
  input wire logic serial_clk_in,
  input wire logic serial_load_in,
  input wire logic enh_write_enable_in,
  input wire logic serial_source_select_in,
  input wire logic parallel_source_select_in,
  input wire logic enhancement_write_strobe_in,
  input wire logic main_upper_write_strobe_in,
  input wire logic main_lower_write_strobe_in,
  input wire logic swallow_write_strobe_in,
  input wire logic hop_write_strobe_in,
  input wire logic serial_mode_select_in,
  input wire logic direct_mode_select_in,
  input wire logic enh_mode_b_in,
  input wire logic [pcpp_pkg::DATA_W-1:0] par_data_in,
  input wire logic direct_pre_en_b_in,
  input wire logic [pcpp_pkg::REF_W-1:0] direct_ref_in,
  input wire logic [pcpp_pkg::MAIN_W-1:0] direct_main_in,
  input wire logic [pcpp_pkg::SWAL_W-1:0] direct_swallow_in,
  output logic [pcpp_pkg::REF_W-1:0] ref_count_out,
  output logic [pcpp_pkg::MAIN_W-1:0] main_count_out,
  output logic [pcpp_pkg::SWAL_W-1:0] swallow_count_out,
  output logic prescaler_bypass_out,
  output logic [pcpp_pkg::ENH_W-1:0] enhancement_out,
  output logic [1:0] mode_out
);
  import pcpp_pkg::*;

  pcpp_pin_if #(.W(PIN_W)) pin_bus ();
  logic [PIN_W-1:0] lvl;
  logic [PIN_W-1:0] rise;
  logic [DATA_W-1:0] data_lvl;

  // gather every pin into one vector for the synchroniser
  assign pin_bus.raw = {direct_swallow_in, direct_main_in, direct_ref_in,
    direct_pre_en_b_in, par_data_in, enh_mode_b_in, direct_mode_select_in,
    serial_mode_select_in, hop_write_strobe_in, swallow_write_strobe_in,
    main_lower_write_strobe_in, main_upper_write_strobe_in,
    enhancement_write_strobe_in, parallel_source_select_in,
    serial_source_select_in, enh_write_enable_in, serial_load_in,
    serial_clk_in, serial_data_in};
  assign lvl = pin_bus.level;
  assign rise = pin_bus.rise;
  assign data_lvl = lvl[PIN_DATA +: DATA_W]; // RQ14

  // one filter per pin; strobes act at their clean rise, not the raw one
  pcpp_pin_sync #(.W(PIN_W)) u_sync (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .clk_en_in(clk_en_in),
    .pins(pin_bus)
  );

  // interface mode
  pcpp_mode_t mode_reg, mode_next;

  // direct select wins over the serial/parallel select
  always_comb begin
    mode_next = mode_reg;
    if (clk_en_in) begin
      if (lvl[PIN_DIRSEL]) begin
        mode_next = PCPP_MODE_DIR; // RQ12
      end else if (lvl[PIN_SERSEL]) begin
        mode_next = PCPP_MODE_SER; // RQ11
      end else begin
        mode_next = PCPP_MODE_PAR; // RQ11
      end
    end
  end

  // mode lags the clean pins by one edge, so every write sees a settled mode
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mode_reg <= PCPP_MODE_PAR;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // primary, secondary and enhancement registers
  logic [PRIM_W-1:0] prim_reg, prim_next;
  logic [PRIM_W-1:0] sec_reg, sec_next;
  logic [ENH_W-1:0] enh_reg, enh_next;

  always_comb begin
    prim_next = prim_reg;
    sec_next = sec_reg;
    enh_next = enh_reg;
    if (clk_en_in) begin
      case (mode_reg)
        PCPP_MODE_SER: begin
          // new bit enters at bit 0, first bit ends on top
          if (rise[PIN_SCLK]) begin
            if (lvl[PIN_EWEN]) begin
              enh_next = {enh_reg[ENH_W-2:0], lvl[PIN_SDATA]}; // RQ2 RQ17 RQ1
            end else begin
              prim_next = {prim_reg[PRIM_W-2:0], lvl[PIN_SDATA]}; // RQ2 RQ17 RQ1
            end
          end
          // old primary is copied even if a shift lands the same cycle
          if (rise[PIN_SLOAD] || rise[PIN_HOP]) begin
            sec_next = prim_reg; // RQ15 RQ10
          end
        end
        PCPP_MODE_PAR: begin
          // strobes in one cycle each write their own field
          if (rise[PIN_ESTB]) begin
            enh_next = data_lvl; // RQ6
          end
          if (rise[PIN_MLSTB]) begin
            prim_next[FLD_MLO_LSB +: FLD_MLO_W] = data_lvl[FLD_MLO_W-1:0]; // RQ8
            prim_next[FLD_PRE_BIT] = data_lvl[DATA_W-1]; // RQ8
          end
          if (rise[PIN_MUSTB]) begin
            prim_next[FLD_MHI_LSB +: FLD_MHI_W] = data_lvl[1:0]; // RQ7
            prim_next[FLD_RHI_LSB +: FLD_RHI_W] = data_lvl[3:2]; // RQ7
          end
          if (rise[PIN_SWSTB]) begin
            prim_next[FLD_A_LSB +: FLD_A_W] = data_lvl[3:0]; // RQ9
            prim_next[FLD_RLO_LSB +: FLD_RLO_W] = data_lvl[7:4]; // RQ9
          end
          if (rise[PIN_HOP]) begin
            sec_next = prim_reg; // RQ10
          end
        end
        default: begin
          // direct mode writes nothing
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      prim_reg <= PRIM_RST;
      sec_reg <= PRIM_RST;
      enh_reg <= ENH_RST;
    end else begin
      prim_reg <= prim_next;
      sec_reg <= sec_next;
      enh_reg <= enh_next;
    end
  end

  // counter value selection
  logic [PRIM_W-1:0] src_word;
  logic src_primary;
  logic [REF_W-1:0] ref_next;
  logic [MAIN_W-1:0] main_next;
  logic [SWAL_W-1:0] swal_next;
  logic bypass_next;
  logic [ENH_W-1:0] enh_out_next;

  always_comb begin
    src_primary = (mode_reg == PCPP_MODE_SER) ? lvl[PIN_SSEL] : lvl[PIN_PSEL]; // RQ3 RQ4
    src_word = src_primary ? prim_reg : sec_reg;
    ref_next = ref_count_out;
    main_next = main_count_out;
    swal_next = swallow_count_out;
    bypass_next = prescaler_bypass_out;
    enh_out_next = enhancement_out;
    if (clk_en_in) begin
      case (mode_reg)
        PCPP_MODE_DIR: begin
          ref_next = lvl[PIN_DREF +: REF_W]; // RQ12
          main_next = lvl[PIN_DMAIN +: MAIN_W]; // RQ12
          swal_next = lvl[PIN_DSWAL +: SWAL_W]; // RQ13
          bypass_next = lvl[PIN_DPRE]; // RQ5
          enh_out_next = ENH_RST;
        end
        PCPP_MODE_SER, PCPP_MODE_PAR: begin
          ref_next = {src_word[FLD_RHI_LSB +: FLD_RHI_W], src_word[FLD_RLO_LSB +: FLD_RLO_W]};
          main_next = {src_word[FLD_MHI_LSB +: FLD_MHI_W], src_word[FLD_MLO_LSB +: FLD_MLO_W]};
          swal_next = src_word[FLD_A_LSB +: FLD_A_W];
          bypass_next = src_word[FLD_PRE_BIT]; // RQ5
          // enhancement bits only act while the mode pin is low
          enh_out_next = lvl[PIN_ENHMODE] ? ENH_RST : enh_reg; // RQ16
        end
        default: begin
          enh_out_next = ENH_RST;
        end
      endcase
    end
  end

  // every output straight from a flop
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ref_count_out <= '0;
      main_count_out <= '0;
      swallow_count_out <= '0;
      prescaler_bypass_out <= 1'b0;
      enhancement_out <= ENH_RST;
      mode_out <= 2'h0;
    end else begin
      ref_count_out <= ref_next;
      main_count_out <= main_next;
      swallow_count_out <= swal_next;
      prescaler_bypass_out <= bypass_next;
      enhancement_out <= enh_out_next;
      mode_out <= mode_next;
    end
  end

  // checks on the loading behaviour
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);

  // mode qualifiers that the checks below are built on
  sequence s_ser;
    clk_en_in && mode_reg == PCPP_MODE_SER;
  endsequence
  sequence s_par;
    clk_en_in && mode_reg == PCPP_MODE_PAR;
  endsequence
  sequence s_dir;
    clk_en_in && mode_reg == PCPP_MODE_DIR;
  endsequence

  AST_SER_PRIM_SHIFT: assert property ( // RQ1 RQ2 RQ17
    s_ser ##0 (rise[PIN_SCLK] && !lvl[PIN_EWEN]) |=>
      prim_reg[0] == $past(lvl[PIN_SDATA]) &&
      prim_reg[PRIM_W-1:1] == $past(prim_reg[PRIM_W-2:0]))
    else $error("primary shift wrong");
  AST_SER_ENH_SHIFT: assert property ( // RQ2 RQ17
    s_ser ##0 (rise[PIN_SCLK] && lvl[PIN_EWEN]) |=>
      enh_reg == {$past(enh_reg[ENH_W-2:0]), $past(lvl[PIN_SDATA])} &&
      $stable(prim_reg))
    else $error("enhancement shift wrong");
  AST_SER_LOAD: assert property ( // RQ15
    s_ser ##0 rise[PIN_SLOAD] |=> sec_reg == $past(prim_reg))
    else $error("serial load did not copy primary");
  AST_HOP: assert property ( // RQ10
    (s_ser or s_par) ##0 rise[PIN_HOP] |=> sec_reg == $past(prim_reg))
    else $error("hop did not copy primary");
  AST_PAR_ENH: assert property ( // RQ6
    s_par ##0 rise[PIN_ESTB] |=> enh_reg == $past(data_lvl))
    else $error("enhancement capture wrong");
  AST_PAR_MUPPER: assert property ( // RQ7 RQ14
    s_par ##0 rise[PIN_MUSTB] |=>
      prim_reg[FLD_RHI_LSB +: FLD_RHI_W] == $past(data_lvl[3:2]) &&
      prim_reg[FLD_MHI_LSB +: FLD_MHI_W] == $past(data_lvl[1:0]))
    else $error("main upper latch wrong");
  AST_PAR_MLOWER: assert property ( // RQ8 RQ14
    s_par ##0 rise[PIN_MLSTB] |=>
      prim_reg[FLD_PRE_BIT:FLD_MLO_LSB] == $past(data_lvl))
    else $error("main lower latch wrong");
  AST_PAR_SWALLOW: assert property ( // RQ9
    s_par ##0 rise[PIN_SWSTB] |=>
      prim_reg[FLD_RLO_LSB +: FLD_RLO_W] == $past(data_lvl[7:4]) &&
      prim_reg[FLD_A_LSB +: FLD_A_W] == $past(data_lvl[3:0]))
    else $error("swallow latch wrong");
  AST_SRC_SELECT: assert property ( // RQ3 RQ4 RQ5
    (s_ser or s_par) |=> main_count_out ==
      ($past(src_primary) ? {$past(prim_reg[17:16]), $past(prim_reg[14:8])}
                          : {$past(sec_reg[17:16]), $past(sec_reg[14:8])}) &&
      prescaler_bypass_out == ($past(src_primary) ? $past(prim_reg[FLD_PRE_BIT])
                                                  : $past(sec_reg[FLD_PRE_BIT])))
    else $error("counter source select wrong");
  // clean swallow pins as the direct check sees them
  logic [SWAL_W-1:0] direct_swallow_lvl;
  assign direct_swallow_lvl = lvl[PIN_DSWAL +: SWAL_W];

  AST_DIRECT: assert property ( // RQ12 RQ13 RQ5
    s_dir |=> swallow_count_out == $past(direct_swallow_lvl) &&
      ref_count_out == $past(lvl[PIN_DREF +: REF_W]) &&
      main_count_out == $past(lvl[PIN_DMAIN +: MAIN_W]) &&
      prescaler_bypass_out == $past(lvl[PIN_DPRE]) && enhancement_out == ENH_RST)
    else $error("direct mode values wrong");
  // direct mode must leave every stored word as it was
  AST_DIR_NO_WRITE: assert property ( // RQ12
    s_dir |=> $stable(prim_reg) && $stable(sec_reg) && $stable(enh_reg))
    else $error("register written in direct mode");
  // a main lower strobe in serial mode is refused
  AST_SER_REFUSE_PAR: assert property ( // RQ11
    s_ser ##0 (rise[PIN_MLSTB] && !rise[PIN_SCLK]) |=> $stable(prim_reg))
    else $error("parallel strobe accepted in serial mode");
  AST_ENH_GATE: assert property ( // RQ16
    (s_ser or s_par) ##0 lvl[PIN_ENHMODE] |=> enhancement_out == ENH_RST)
    else $error("enhancement applied while mode pin high");
  // mode register and its output copy follow the clean pins one edge later
  AST_MODE: assert property ( // RQ11
    clk_en_in && !lvl[PIN_DIRSEL] && lvl[PIN_SERSEL] |=>
      mode_reg == PCPP_MODE_SER && mode_out == PCPP_MODE_SER)
    else $error("serial mode not taken");
  AST_MODE_PAR: assert property ( // RQ11
    clk_en_in && !lvl[PIN_DIRSEL] && !lvl[PIN_SERSEL] |=>
      mode_reg == PCPP_MODE_PAR && mode_out == PCPP_MODE_PAR)
    else $error("parallel mode not taken");
  AST_MODE_DIR: assert property ( // RQ12
    clk_en_in && lvl[PIN_DIRSEL] |=> mode_reg == PCPP_MODE_DIR && mode_out == PCPP_MODE_DIR)
    else $error("direct mode not taken");
  // a low enable freezes stored words, mode and outputs alike
  AST_FREEZE: assert property (
    !clk_en_in |=> $stable(prim_reg) && $stable(sec_reg) && $stable(enh_reg) &&
      $stable(mode_reg) && $stable(main_count_out) && $stable(ref_count_out) &&
      $stable(swallow_count_out) && $stable(enhancement_out))
    else $error("state moved with enable low");
endmodule

// *** pcpp_ctrl_model.sv ***
// Purpose: controller model that drives the serial and parallel programming pins
// Assumes: the caller sits on a rising clk_in edge when it calls a task
// Notes: between frames the serial lines rest low, the level the pull-downs give
`timescale 1ns/1ns
module pcpp_ctrl_model (
  input wire logic clk_in,
  output logic sdata_out,
  output logic sclk_out,
  output logic [5:0] stb_out,
  output logic [7:0] data_out
);
  // idle levels at time zero
  initial begin
    sdata_out = 1'b0;
    sclk_out = 1'b0;
    stb_out = 6'h00;
    data_out = 8'h00;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // 4 low and 4 high clocks make the 320 ns serial clock; load stays low meanwhile
  task automatic send(input logic [19:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      sdata_out <= v[i];
      tick(4);
      sclk_out <= 1'b1;
      tick(4);
      sclk_out <= 1'b0;
    end
    sdata_out <= 1'b0;
  endtask
  // data settles 5 clocks ahead, since the pins pass a 3-flop filter
  task automatic pulse(input int i, input logic [7:0] d);
    data_out <= d;
    tick(5);
    stb_out[i] <= 1'b1;
    tick(5);
    stb_out[i] <= 1'b0;
    tick(5);
  endtask
endmodule

// *** tb.sv ***
// Purpose: self-checking bench of the counter programming port
// Assumes: pins change on rising clk_in edges; outputs are read 8 clocks later
// Notes: rows cover parallel loads; the hand tests cover serial, direct and refusals
`timescale 1ns/1ns
module tb;
  import pcpp_pkg::*;
  typedef struct {logic [7:0] sw; logic [7:0] lo; logic [7:0] up; logic [19:0] word;} pcpp_row_t;
  logic clk_in;
  logic rst_b_in;
  logic clk_en_in;
  logic sdata;
  logic sclk;
  logic [5:0] stb;
  logic [7:0] pdata;
  logic ewen;
  logic ssel;
  logic psel;
  logic sersel;
  logic dirsel;
  logic enhb;
  logic dpre;
  logic [5:0] dref;
  logic [8:0] dmain;
  logic [3:0] dswal;
  logic [5:0] ref_o;
  logic [8:0] main_o;
  logic [3:0] swal_o;
  logic byp_o;
  logic [7:0] enh_o;
  logic [1:0] mode_o;
  int err_total = 0;
  int compares = 0;
  // swallow, lower and upper bytes beside the primary word they build
  pcpp_row_t rows [2] = '{'{8'h5a, 8'h83, 8'h0e, 20'he835a}, '{8'ha5, 8'h7f, 8'h01, 20'h17fa5}};
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  pcpp_ctrl_model ctrl_u (.clk_in(clk_in), .sdata_out(sdata), .sclk_out(sclk),
    .stb_out(stb), .data_out(pdata));
  pcpp_port dut_u (.clk_in(clk_in), .rst_b_in(rst_b_in), .clk_en_in(clk_en_in),
    .serial_data_in(sdata), .serial_clk_in(sclk), .serial_load_in(stb[5]),
    .enh_write_enable_in(ewen), .serial_source_select_in(ssel),
    .parallel_source_select_in(psel), .enhancement_write_strobe_in(stb[0]),
    .main_upper_write_strobe_in(stb[1]), .main_lower_write_strobe_in(stb[2]),
    .swallow_write_strobe_in(stb[3]), .hop_write_strobe_in(stb[4]),
    .serial_mode_select_in(sersel), .direct_mode_select_in(dirsel), .enh_mode_b_in(enhb),
    .par_data_in(pdata), .direct_pre_en_b_in(dpre), .direct_ref_in(dref),
    .direct_main_in(dmain), .direct_swallow_in(dswal), .ref_count_out(ref_o),
    .main_count_out(main_o), .swallow_count_out(swal_o), .prescaler_bypass_out(byp_o),
    .enhancement_out(enh_o), .mode_out(mode_o));
  task automatic cmp(input string what, input logic [19:0] exp, input logic [19:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  // fields of a primary word as the counters should show them
  task automatic check_word(input logic [19:0] w);
    cmp("swallow", 20'(w[3:0]), 20'(swal_o));
    cmp("reference", 20'({w[19:18], w[7:4]}), 20'(ref_o));
    cmp("main", 20'({w[17:16], w[14:8]}), 20'(main_o));
    cmp("bypass", 20'(w[15]), 20'(byp_o));
  endtask
  task automatic wrap_up;
    $display("compares %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // watchdog, far beyond the roughly 500 clocks the tests need
  initial begin
    #(40 * 20000);
    err_total++;
    wrap_up();
  end
  initial begin
    // pin levels at time zero, reset held low
    rst_b_in <= 1'b0;
    clk_en_in <= 1'b1;
    ewen <= 1'b0;
    ssel <= 1'b1;
    psel <= 1'b1;
    sersel <= 1'b0;
    dirsel <= 1'b0;
    enhb <= 1'b1;
    dpre <= 1'b1;
    dref <= 6'h2b;
    dmain <= 9'h155;
    dswal <= 4'h9;
    repeat (6) @(posedge clk_in);
    rst_b_in <= 1'b1;
    ctrl_u.tick(2);
    check_word(20'h00000);
    cmp("mode", 20'(PCPP_MODE_PAR), 20'(mode_o));
    cmp("enhancement", 20'h0, 20'(enh_o));
    $display("test reset done");
    // parallel loads; the first row is copied to the secondary by a hop
    foreach (rows[i]) begin
      ctrl_u.pulse(3, rows[i].sw);
      ctrl_u.pulse(2, rows[i].lo);
      ctrl_u.pulse(1, rows[i].up);
      ctrl_u.tick(8);
      check_word(rows[i].word);
      if (i == 0) ctrl_u.pulse(4, 8'h00);
      $display("test row %0d done", i);
    end
    psel <= 1'b0;
    ctrl_u.tick(8);
    check_word(rows[0].word);
    enhb <= 1'b0;
    ctrl_u.pulse(0, 8'h3a);
    ctrl_u.tick(8);
    cmp("enhancement", 20'h3a, 20'(enh_o));
    $display("test parallel select done");
    // serial word, secondary shown until the load rises
    sersel <= 1'b1;
    ssel <= 1'b0;
    ctrl_u.tick(8);
    cmp("mode", 20'(PCPP_MODE_SER), 20'(mode_o));
    ctrl_u.send(20'hb4c96, 20);
    ctrl_u.tick(8);
    check_word(rows[0].word);
    ssel <= 1'b1;
    ctrl_u.tick(8);
    check_word(20'hb4c96);
    ctrl_u.pulse(2, 8'hff);
    ctrl_u.tick(8);
    check_word(20'hb4c96);
    ssel <= 1'b0;
    ctrl_u.pulse(5, 8'h00);
    ctrl_u.tick(8);
    check_word(20'hb4c96);
    $display("test serial word done");
    // serial enhancement byte leaves the primary alone
    ewen <= 1'b1;
    ctrl_u.tick(2);
    ctrl_u.send(20'h000c5, 8);
    ewen <= 1'b0;
    ssel <= 1'b1;
    ctrl_u.tick(8);
    cmp("enhancement", 20'hc5, 20'(enh_o));
    check_word(20'hb4c96);
    enhb <= 1'b1;
    ctrl_u.tick(8);
    cmp("enhancement", 20'h0, 20'(enh_o));
    $display("test serial enhancement done");
    // direct pins override with serial still selected
    dirsel <= 1'b1;
    ctrl_u.tick(8);
    cmp("mode", 20'(PCPP_MODE_DIR), 20'(mode_o));
    cmp("reference", 20'h2b, 20'(ref_o));
    cmp("main", 20'h155, 20'(main_o));
    cmp("swallow", 20'h9, 20'(swal_o));
    cmp("bypass", 20'h1, 20'(byp_o));
    dswal <= 4'h6;
    dpre <= 1'b0;
    ctrl_u.tick(8);
    cmp("swallow", 20'h6, 20'(swal_o));
    cmp("bypass", 20'h0, 20'(byp_o));
    $display("test direct done");
    // enable low freezes the whole path; new pin values land once it returns
    clk_en_in <= 1'b0;
    dswal <= 4'h3;
    dref <= 6'h14;
    dmain <= 9'h0aa;
    ctrl_u.tick(8);
    cmp("swallow", 20'h6, 20'(swal_o));
    cmp("reference", 20'h2b, 20'(ref_o));
    clk_en_in <= 1'b1;
    ctrl_u.tick(8);
    cmp("swallow", 20'h3, 20'(swal_o));
    cmp("reference", 20'h14, 20'(ref_o));
    cmp("main", 20'h0aa, 20'(main_o));
    $display("test clock enable done");
    // reset in mid-run clears everything; direct values return after it
    rst_b_in <= 1'b0;
    ctrl_u.tick(2);
    check_word(20'h00000);
    cmp("mode", 20'(PCPP_MODE_PAR), 20'(mode_o));
    rst_b_in <= 1'b1;
    ctrl_u.tick(8);
    cmp("mode", 20'(PCPP_MODE_DIR), 20'(mode_o));
    cmp("main", 20'h0aa, 20'(main_o));
    $display("test mid-run reset done");
    wrap_up();
  end
endmodule
